// file: rtl/vcr_pkg.sv
/*
  Package for the amplifier-chain configuration bank: register addresses,
  field positions, reset values and field encodings.
  Assumes a 100 MHz sys_clk and a serial port that writes 24-bit frames.
*/
package vcr_pkg;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned FRAME_W = 24;
  localparam int unsigned NUM_CH  = 8;

  localparam logic [7:0] ADDR_FILTER_AMP = 8'h33;
  localparam logic [7:0] ADDR_INPUT_TERM = 8'h34;
  localparam logic [7:0] ADDR_CH_POWER   = 8'h35;
  localparam logic [7:0] ADDR_CH_GAIN    = 8'h39;

  localparam logic [15:0] RST_FILTER_AMP = 16'h0000;
  localparam logic [15:0] RST_INPUT_TERM = 16'h0000;
  localparam logic [15:0] RST_CH_POWER   = 16'h0000;
  localparam logic [15:0] RST_CH_GAIN    = 16'h0000;

  // Writable bit masks; reserved bits hold zero
  localparam logic [15:0] MASK_FILTER_AMP = 16'h20fe;
  localparam logic [15:0] MASK_INPUT_TERM = 16'hf7ff;
  localparam logic [15:0] MASK_CH_POWER   = 16'hfcff;
  localparam logic [15:0] MASK_CH_GAIN    = 16'hffff;

  localparam int unsigned POS_CUTOFF      = 1;
  localparam int unsigned POS_AMP_LOOP    = 4;
  localparam int unsigned POS_CLAMP_LVL   = 5;
  localparam int unsigned POS_CLAMP_OFF   = 7;
  localparam int unsigned POS_AMP_GAIN    = 13;
  localparam int unsigned POS_TERM_RES    = 0;
  localparam int unsigned POS_TERM_INDIV  = 5;
  localparam int unsigned POS_TERM_PRESET = 6;
  localparam int unsigned POS_TERM_ON     = 8;
  localparam int unsigned POS_IN_CLAMP    = 9;
  localparam int unsigned POS_FRONT_LOOP  = 12;
  localparam int unsigned POS_FRONT_GAIN  = 13;
  localparam int unsigned POS_PER_CH_GAIN = 15;
  localparam int unsigned POS_SHUTDOWN    = 0;
  localparam int unsigned POS_LOW_POWER   = 10;
  localparam int unsigned POS_MID_POWER   = 11;

  localparam logic [2:0] CUT_15MHZ = 3'h0;
  localparam logic [2:0] CUT_20MHZ = 3'h2;
  localparam logic [2:0] CUT_30MHZ = 3'h3;
  localparam logic [2:0] CUT_10MHZ = 3'h4;

  localparam logic [1:0] GAIN_18DB = 2'h0;
  localparam logic [1:0] GAIN_24DB = 2'h1;
  localparam logic [1:0] GAIN_12DB = 2'h2;

  localparam logic [1:0] PRESET_50  = 2'h0;

  // Active termination decode result
  localparam logic [2:0] TERM_OFF    = 3'h0;
  localparam logic [2:0] TERM_HIGHZ  = 3'h1;
  localparam logic [2:0] TERM_INDIV  = 3'h2;
  localparam logic [2:0] TERM_PRESET = 3'h3;

  localparam logic [4:0] SHIFT_CNT_RST = 5'h00;

  typedef enum logic [2:0] {
    PM_LOW_NOISE = 3'b001,
    PM_LOW_POWER = 3'b010,
    PM_MID_POWER = 3'b100
  } vcr_power_t;
endpackage

// file: rtl/vcr_reg_store.sv
/*
  Four-word configuration store with per-word write masks.
  Assumes write strobe and data from the same clock domain.
*/
`timescale 1ns/1ps
module vcr_reg_store
  import vcr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Write side
  input  wire logic        wrEn,
  input  wire logic [1:0]  wrSel,
  input  wire logic [15:0] wrData,
  // Stored words
  output logic [15:0]      filterAmp,
  output logic [15:0]      inputTerm,
  output logic [15:0]      chPower,
  output logic [15:0]      chGain
);
  import vcr_pkg::*;

  typedef struct packed {
    logic [3:0][15:0] word;
  } vcr_store_t;

  localparam logic [3:0][15:0] MASKS = {MASK_CH_GAIN, MASK_CH_POWER, MASK_INPUT_TERM, MASK_FILTER_AMP};
  localparam logic [3:0][15:0] RSTS  = {RST_CH_GAIN, RST_CH_POWER, RST_INPUT_TERM, RST_FILTER_AMP};

  vcr_store_t stateQ;
  vcr_store_t stateD;

  always_comb begin
    stateD = stateQ;
    if (wrEn) begin
      stateD.word[wrSel] = wrData & MASKS[wrSel];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stateQ.word <= RSTS;
    end else begin
      stateQ <= stateD;
    end
  end

  assign filterAmp = stateQ.word[0];
  assign inputTerm = stateQ.word[1];
  assign chPower   = stateQ.word[2];
  assign chGain    = stateQ.word[3];

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (filterAmp[0] == 1'b0) && (inputTerm[11] == 1'b0) && (chPower[9:8] == 2'h0))
    else $error("Reserved bit stored as one");
endmodule

// file: rtl/vcr_term_decode.sv
/*
  Active termination and gain decode for one channel.
  Assumes configuration fields already registered.
*/
`timescale 1ns/1ps
module vcr_term_decode
  import vcr_pkg::*;
(
  // Configuration
  input  wire logic       termOn,
  input  wire logic       termIndiv,
  input  wire logic [1:0] presetSel,
  input  wire logic [1:0] commonGain,
  input  wire logic [1:0] channelGain,
  input  wire logic       perChannelOn,
  // Decoded
  output logic [1:0]      gainUsed,
  output logic [2:0]      termMode
);
  import vcr_pkg::*;

  always_comb begin
    gainUsed = perChannelOn ? channelGain : commonGain;
    if (!termOn) begin
      termMode = TERM_OFF;
    end else if (termIndiv) begin
      termMode = TERM_INDIV;
    end else if (presetSel == PRESET_50 && gainUsed == GAIN_12DB) begin
      termMode = TERM_HIGHZ;
    end else begin
      termMode = TERM_PRESET;
    end
  end
endmodule

// file: rtl/vcr_config_bank.sv
/*
  Configuration bank for the eight-channel amplifier chain, written over
  a three-wire serial port (24-bit frame: 8-bit address, 16-bit data).
  Assumes serial pins are asynchronous and slower than sys_clk / 4.
*/
//
// Contract
// - Cutoff code selects filter corner frequency
// - Bit set turns amplifier offset loop off
// - Clamp threshold field sets clamp level
// - Bit set disables amplifier current clamp
// - Bit selects amplifier gain 24 or 30dB
// - Resistor field applies only when individual set
// - Individual bit enables resistor-level termination control
// - Preset field picks 50 to 400 ohm
// - Preset 00 at 12dB means high impedance
// - Master bit enables active termination
// - Input clamp field selects clamp level
// - Bit set turns front offset loop off
// - Front gain 18/24/12dB, code 11 forbidden
// - Per-channel bit selects individual gain fields
// - Shutdown mask bit n stops channel n+1
// - Low-power bit; keep middle-power bit clear
// - Middle-power bit; keep low-power bit clear
// - Channel gain word used when per-channel on
`timescale 1ns/1ps
module vcr_config_bank
  import vcr_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // Serial control port
  input  wire logic               serClk,
  input  wire logic               serEnable_n,
  input  wire logic               serData,
  // Filter and amplifier stage
  output logic [2:0]              filter_cutoff_select,
  output logic                    amp_stage_offset_loop_off,
  output logic [1:0]              amp_clamp_threshold,
  output logic                    amp_clamp_off,
  output logic                    amp_stage_gain_select,
  // Front amplifier and termination
  output logic [4:0]              termResistorSel,
  output logic [1:0]              termination_preset_select,
  output logic [1:0]              input_clamp_select,
  output logic                    front_amp_offset_loop_off,
  output logic                    per_channel_gain_on,
  output logic [NUM_CH-1:0][1:0]  chGainUsed,
  output logic [NUM_CH-1:0][2:0]  chTermMode,
  // Power
  output logic [NUM_CH-1:0]       channel_shutdown_mask,
  output vcr_pkg::vcr_power_t     powerMode,
  output logic                    configError
);
  import vcr_pkg::*;

  typedef struct packed {
    logic [2:0]  clkSync;
    logic [1:0]  enSync;
    logic [1:0]  datSync;
    logic [23:0] shift;
    logic [4:0]  bitCnt;
    logic        wrEn;
    logic [1:0]  wrSel;
    logic [15:0] wrData;
  } vcr_state_t;

  vcr_state_t stateQ;
  vcr_state_t stateD;

  logic [15:0] filterAmp;
  logic [15:0] inputTerm;
  logic [15:0] chPower;
  logic [15:0] chGain;
  logic        serRise;
  logic        frameOpen;
  logic [7:0]  frameAddr;

  // Edge detect reads only the second and third sync stages
  assign serRise   = stateQ.clkSync[1] && !stateQ.clkSync[2];
  assign frameOpen = !stateQ.enSync[1];
  assign frameAddr = stateQ.shift[23:16];

  always_comb begin
    stateD         = stateQ;
    stateD.clkSync = {stateQ.clkSync[1:0], serClk};
    stateD.enSync  = {stateQ.enSync[0], serEnable_n};
    stateD.datSync = {stateQ.datSync[0], serData};
    stateD.wrEn    = 1'b0;
    if (!frameOpen) begin
      stateD.bitCnt = SHIFT_CNT_RST;
    end else if (serRise && stateQ.bitCnt < 5'(FRAME_W)) begin
      stateD.shift  = {stateQ.shift[22:0], stateQ.datSync[1]};
      stateD.bitCnt = stateQ.bitCnt + 5'h01;
    end
    // Commit at most one word per frame, after the last data bit
    if (frameOpen && serRise == 1'b0 && stateQ.bitCnt == 5'(FRAME_W)) begin
      stateD.bitCnt = stateQ.bitCnt + 5'h01;
      stateD.wrData = stateQ.shift[15:0];
      case (frameAddr)
        ADDR_FILTER_AMP: begin
          stateD.wrSel = 2'h0;
          stateD.wrEn  = 1'b1;
        end
        ADDR_INPUT_TERM: begin
          stateD.wrSel = 2'h1;
          stateD.wrEn  = 1'b1;
        end
        ADDR_CH_POWER: begin
          stateD.wrSel = 2'h2;
          stateD.wrEn  = 1'b1;
        end
        ADDR_CH_GAIN: begin
          stateD.wrSel = 2'h3;
          stateD.wrEn  = 1'b1;
        end
        default: begin
          stateD.wrEn = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stateQ <= '{clkSync: 3'h0, enSync: 2'h3, datSync: 2'h0, shift: 24'h000000,
                  bitCnt: SHIFT_CNT_RST, wrEn: 1'b0, wrSel: 2'h0, wrData: 16'h0000};
    end else begin
      stateQ <= stateD;
    end
  end

  vcr_reg_store u_store (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .wrEn      (stateQ.wrEn),
    .wrSel     (stateQ.wrSel),
    .wrData    (stateQ.wrData),
    .filterAmp (filterAmp),
    .inputTerm (inputTerm),
    .chPower   (chPower),
    .chGain    (chGain)
  );

  // Field fan-out to the analog controls
  assign filter_cutoff_select      = filterAmp[POS_CUTOFF +: 3];
  assign amp_stage_offset_loop_off = filterAmp[POS_AMP_LOOP];
  assign amp_clamp_threshold       = filterAmp[POS_CLAMP_LVL +: 2];
  assign amp_clamp_off             = filterAmp[POS_CLAMP_OFF];
  assign amp_stage_gain_select     = filterAmp[POS_AMP_GAIN];
  assign termResistorSel           = inputTerm[POS_TERM_INDIV] ? inputTerm[POS_TERM_RES +: 5] : 5'h00;
  assign termination_preset_select = inputTerm[POS_TERM_PRESET +: 2];
  assign input_clamp_select        = inputTerm[POS_IN_CLAMP +: 2];
  assign front_amp_offset_loop_off = inputTerm[POS_FRONT_LOOP];
  assign per_channel_gain_on       = inputTerm[POS_PER_CH_GAIN];
  assign channel_shutdown_mask     = chPower[POS_SHUTDOWN +: NUM_CH];

  always_comb begin
    case ({chPower[POS_MID_POWER], chPower[POS_LOW_POWER]})
      2'b01:   powerMode = PM_LOW_POWER;
      2'b10:   powerMode = PM_MID_POWER;
      default: powerMode = PM_LOW_NOISE;
    endcase
  end

  // Flags software misuse: reserved gain code or both power modes set
  always_comb begin
    configError = (inputTerm[POS_FRONT_GAIN +: 2] == 2'h3)
                  || (chPower[POS_LOW_POWER] && chPower[POS_MID_POWER]);
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      vcr_term_decode u_dec (
        .termOn       (inputTerm[POS_TERM_ON]),
        .termIndiv    (inputTerm[POS_TERM_INDIV]),
        .presetSel    (inputTerm[POS_TERM_PRESET +: 2]),
        .commonGain   (inputTerm[POS_FRONT_GAIN +: 2]),
        .channelGain  (chGain[2*ch +: 2]),
        .perChannelOn (inputTerm[POS_PER_CH_GAIN]),
        .gainUsed     (chGainUsed[ch]),
        .termMode     (chTermMode[ch])
      );
    end
  endgenerate

  sequence s_frame_done;
    frameOpen && stateQ.bitCnt == 5'(FRAME_W) && !serRise && frameAddr == ADDR_INPUT_TERM;
  endsequence

  // One write strobe per stored word, except the channel gain word
  sequence s_filter_write;
    stateQ.wrEn && stateQ.wrSel == 2'h0;
  endsequence

  sequence s_term_write;
    stateQ.wrEn && stateQ.wrSel == 2'h1;
  endsequence

  sequence s_power_write;
    stateQ.wrEn && stateQ.wrSel == 2'h2;
  endsequence

  a_term_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_frame_done |-> ##2 (inputTerm == ($past(stateQ.shift[15:0], 2) & MASK_INPUT_TERM)))
    else $error("Termination word not stored two cycles after frame");

  // Field routing, one cycle after the store strobe
  a_cutoff_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_filter_write |=> filter_cutoff_select == $past(stateQ.wrData[POS_CUTOFF +: 3]))
    else $error("Cutoff field misrouted");

  a_cutoff_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !stateQ.wrEn |=> $stable(filter_cutoff_select))
    else $error("Cutoff field changed without a write");

  a_amp_loop_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_filter_write |=> amp_stage_offset_loop_off == $past(stateQ.wrData[POS_AMP_LOOP]))
    else $error("Amplifier offset loop bit misrouted");

  a_clamp_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_filter_write |=> amp_clamp_threshold == $past(stateQ.wrData[POS_CLAMP_LVL +: 2]))
    else $error("Clamp threshold misrouted");

  a_clamp_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_filter_write |=> amp_clamp_off == $past(stateQ.wrData[POS_CLAMP_OFF]))
    else $error("Clamp disable bit misrouted");

  a_amp_gain: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_filter_write |=> amp_stage_gain_select == $past(stateQ.wrData[POS_AMP_GAIN]))
    else $error("Amplifier gain bit misrouted");

  a_shutdown_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_power_write |=> channel_shutdown_mask == $past(stateQ.wrData[POS_SHUTDOWN +: NUM_CH]))
    else $error("Channel shutdown mask misrouted");

  a_preset_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_term_write |=> termination_preset_select == $past(stateQ.wrData[POS_TERM_PRESET +: 2]))
    else $error("Termination preset misrouted");

  // Decode of the stored words
  a_preset_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (inputTerm[8] && !inputTerm[5] && inputTerm[7:6] != 2'h0) |-> chTermMode[1] == TERM_PRESET)
    else $error("Preset termination not selected");

  a_highz_preset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (inputTerm[8] && !inputTerm[5] && inputTerm[7:6] == 2'h0 && !inputTerm[15] && inputTerm[14:13] == 2'h2)
    |-> chTermMode[0] == TERM_HIGHZ)
    else $error("Preset zero at 12dB not high impedance");

  a_term_indiv: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (inputTerm[8] && inputTerm[5]) |-> chTermMode[4] == TERM_INDIV)
    else $error("Individual resistor control not selected");

  a_term_master: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !inputTerm[8] |-> chTermMode[7] == TERM_OFF)
    else $error("Termination active while master off");

  a_resistor_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !inputTerm[5] |-> termResistorSel == 5'h00)
    else $error("Resistor field passed without individual enable");

  a_in_clamp: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_term_write |=> input_clamp_select == $past(stateQ.wrData[POS_IN_CLAMP +: 2]))
    else $error("Input clamp field misrouted");

  a_front_loop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_term_write |=> front_amp_offset_loop_off == $past(stateQ.wrData[POS_FRONT_LOOP]))
    else $error("Front offset loop bit misrouted");

  a_gain_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (inputTerm[POS_FRONT_GAIN +: 2] == 2'h3) |-> configError)
    else $error("Reserved front gain code not flagged");

  a_per_ch_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_term_write |=> per_channel_gain_on == $past(stateQ.wrData[POS_PER_CH_GAIN]))
    else $error("Per-channel gain enable misrouted");

  a_gain_common: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !inputTerm[15] |-> chGainUsed[3] == inputTerm[14:13])
    else $error("Common gain not applied to channel four");

  a_chan_gain: assert property (@(posedge sys_clk) disable iff (!reset_n)
    inputTerm[15] |-> chGainUsed[7] == chGain[15:14])
    else $error("Channel eight gain not taken from channel word");

  a_power_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (chPower[11:10] == 2'b01) |-> powerMode == PM_LOW_POWER)
    else $error("Low power mode not selected");

  a_mid_power: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (chPower[11:10] == 2'b10) |-> powerMode == PM_MID_POWER)
    else $error("Middle power mode not selected");

  a_mode_clash: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (chPower[11:10] == 2'b11) |-> (powerMode == PM_LOW_NOISE && configError))
    else $error("Both power bits set not handled");

  a_reset_zero: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> (filterAmp == 16'h0000 && inputTerm == 16'h0000 && chPower == 16'h0000))
    else $error("Register not zero after reset");
endmodule

// file: verif/tb_top.sv
/*
  Self-checking bench for the configuration bank: writes frames over the
  serial port and compares every decoded output with a shadow model.
  Assumes the design package and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin failCount++; \
  $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
  import vcr_pkg::*;

  typedef struct packed {
    logic [15:0] r33;
    logic [15:0] r34;
    logic [15:0] r35;
    logic [15:0] r39;
  } vcr_tb_note_t;

  localparam int LIMIT = 60000;

  logic                   sys_clk;
  logic                   reset_n;
  logic                   serClk;
  logic                   serEnable_n;
  logic                   serData;
  logic [2:0]             cutoff;
  logic                   ampLoopOff;
  logic [1:0]             clampLvl;
  logic                   clampOff;
  logic                   ampGain;
  logic [4:0]             termRes;
  logic [1:0]             preset;
  logic [1:0]             inClamp;
  logic                   frontLoopOff;
  logic                   perChOn;
  logic [NUM_CH-1:0][1:0] chGainUsed;
  logic [NUM_CH-1:0][2:0] chTermMode;
  logic [NUM_CH-1:0]      shutdown;
  vcr_power_t             powerMode;
  logic                   configError;
  vcr_tb_note_t           shadow;
  vcr_tb_note_t           notes[$];
  int                     failCount;
  int                     compares;
  int                     cycles;
  logic [31:0]            rng;
  event                   checkEv;

  vcr_config_bank dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .serClk(serClk), .serEnable_n(serEnable_n),
    .serData(serData), .filter_cutoff_select(cutoff), .amp_stage_offset_loop_off(ampLoopOff),
    .amp_clamp_threshold(clampLvl), .amp_clamp_off(clampOff), .amp_stage_gain_select(ampGain),
    .termResistorSel(termRes), .termination_preset_select(preset), .input_clamp_select(inClamp),
    .front_amp_offset_loop_off(frontLoopOff), .per_channel_gain_on(perChOn),
    .chGainUsed(chGainUsed), .chTermMode(chTermMode), .channel_shutdown_mask(shutdown),
    .powerMode(powerMode), .configError(configError)
  );

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic stopTest();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic note();
    cyc(6);
    notes.push_back(shadow);
    ->checkEv;
  endtask

  // MSB-first frame; released data line shows the inverse of its last bit
  task automatic wr(input logic [7:0] addr, input logic [15:0] data, input int nbits);
    logic [23:0] f;
    f = {addr, data};
    serEnable_n = 1'b0;
    cyc(3);
    for (int i = 0; i < nbits; i++) begin
      serData = f[23-i];
      cyc(5);
      serClk = 1'b1;
      cyc(5);
      serClk = 1'b0;
    end
    cyc(3);
    serEnable_n = 1'b1;
    serData = ~serData;
    if (nbits == 24) begin
      case (addr)
        ADDR_FILTER_AMP: shadow.r33 = data & MASK_FILTER_AMP;
        ADDR_INPUT_TERM: shadow.r34 = data & MASK_INPUT_TERM;
        ADDR_CH_POWER:   shadow.r35 = data & MASK_CH_POWER;
        ADDR_CH_GAIN:    shadow.r39 = data & MASK_CH_GAIN;
        default:         shadow = shadow;
      endcase
    end
    note();
  endtask

  always @(checkEv) begin
    vcr_tb_note_t           e;
    logic [NUM_CH-1:0][1:0] g;
    logic [NUM_CH-1:0][2:0] t;
    logic [2:0]             pm;
    e = notes.pop_front();
    for (int c = 0; c < NUM_CH; c++) begin
      g[c] = e.r34[15] ? e.r39[2*c+:2] : e.r34[14:13];
      t[c] = !e.r34[8] ? 3'h0 : e.r34[5] ? 3'h2 : (e.r34[7:6] == 2'h0 && g[c] == 2'h2) ? 3'h1 : 3'h3;
    end
    pm = (e.r35[10] && !e.r35[11]) ? 3'h2 : (e.r35[11] && !e.r35[10]) ? 3'h4 : 3'h1;
    `CHK(cutoff, e.r33[3:1], "cutoff")
    `CHK(ampLoopOff, e.r33[4], "amp loop")
    `CHK(clampLvl, e.r33[6:5], "clamp level")
    `CHK(clampOff, e.r33[7], "clamp off")
    `CHK(ampGain, e.r33[13], "amp gain")
    `CHK(termRes, e.r34[5] ? e.r34[4:0] : 5'h00, "resistor")
    `CHK(preset, e.r34[7:6], "preset")
    `CHK(chTermMode, t, "term mode")
    `CHK(inClamp, e.r34[10:9], "input clamp")
    `CHK(frontLoopOff, e.r34[12], "front loop")
    `CHK(perChOn, e.r34[15], "per channel")
    `CHK(chGainUsed, g, "gain used")
    `CHK(shutdown, e.r35[7:0], "shutdown")
    `CHK(3'(powerMode), pm, "power mode")
    `CHK(configError, logic'(e.r34[14:13] == 2'h3 || (e.r35[10] && e.r35[11])), "error")
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failCount++;
      stopTest();
    end
  end

  task automatic doReset();
    reset_n = 1'b0;
    cyc(5);
    reset_n = 1'b1;
    shadow = '0;
    note();
  endtask

  initial begin
    logic [7:0] adr[4];
    serClk = 1'b0;
    serEnable_n = 1'b1;
    serData = 1'b0;
    shadow = '0;
    rng = 32'hfa23521c;
    adr = '{ADDR_FILTER_AMP, ADDR_INPUT_TERM, ADDR_CH_POWER, ADDR_CH_GAIN};
    doReset();
    $display("test reset done");
    foreach (adr[k]) wr(adr[k], 16'hffff, 24);
    for (int c = 0; c < 5; c++) wr(ADDR_FILTER_AMP, 16'(c == 1 ? 4 : c) << 1, 24);
    $display("test cutoff done");
    wr(ADDR_INPUT_TERM, 16'h4100, 24);
    wr(ADDR_INPUT_TERM, 16'h4135, 24);
    wr(ADDR_CH_GAIN, 16'h29e4, 24);
    wr(ADDR_INPUT_TERM, 16'h8100, 24);
    wr(ADDR_INPUT_TERM, 16'h6000, 24);
    $display("test termination done");
    for (int p = 0; p < 4; p++) wr(ADDR_CH_POWER, 16'(p << 10) | 16'h00a5, 24);
    $display("test power done");
    wr(8'h36, 16'hffff, 24);
    wr(ADDR_FILTER_AMP, 16'hffff, 23);
    $display("test refused done");
    for (int i = 0; i < 40; i++) begin
      rng = xorshift(rng);
      wr(adr[rng[17:16]], rng[15:0], 24);
    end
    $display("test random done");
    doReset();
    $display("test second reset done");
    cyc(2);
    stopTest();
  end
endmodule
